// ### rtl/fdc_params.svh
`ifndef FDC_PARAMS_SVH
`define FDC_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FDC_OFS_LED2_FLASH 8'h04
`define FDC_OFS_LED1_TORCH 8'h05
`define FDC_OFS_LED2_TORCH 8'h06
`define FDC_OFS_BOOST 8'h07
`define FDC_OFS_TIMING 8'h08
`define FDC_OFS_THERM 8'h09
`define FDC_OFS_FLAGS1 8'h0A
`define FDC_OFS_FLAGS2 8'h0B
`define FDC_OFS_IDENT 8'h0C
`define FDC_OFS_LAST_FLASH 8'h0D
`define FDC_OFS_INDICATOR 8'h39
`define FDC_OFS_UNLOCK 8'h69

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define FDC_RST_LED2_FLASH 7'h3F
`define FDC_RST_LED1_TORCH 8'hBF
`define FDC_RST_LED2_TORCH 7'h3F
`define FDC_RST_BOOST 4'h9
`define FDC_RST_TIMING 7'h1A
`define FDC_RST_THERM 7'h08
`define FDC_RST_INDICATOR 7'h7F
`define FDC_RST_UNLOCK 8'h00

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define FDC_UNLOCK_KEY 8'h02
`define FDC_FOLLOW_BIT 7
`define FDC_SWRST_BIT 7
`define FDC_SHORT_DET_BIT 3
`define FDC_PASS_BIT 2
`define FDC_FREQ_BIT 1
`define FDC_ILIM_BIT 0
`define FDC_RAMP_MSB 6
`define FDC_RAMP_LSB 4
`define FDC_TMO_MSB 3
`define FDC_TMO_LSB 0
`define FDC_POL_BIT 6
`define FDC_OPEN_EN_BIT 5
`define FDC_SHORT_EN_BIT 4
`define FDC_THR_MSB 3
`define FDC_THR_LSB 1
`define FDC_FUNC_BIT 0
`define FDC_FLAGS2_W 5
`define FDC_ZERO8 8'h00

// Identity values are arbitrary
`define FDC_DEV_CODE 3'h5
`define FDC_REV_CODE 3'h1

`endif

// ### rtl/fdc_pkg.sv
package fdc_pkg;

   // Register access from the serial engine
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fdc_req_t;

   // Settings driven to the analog section
   typedef struct packed {
      logic [6:0] led2_flash;
      logic [6:0] led1_torch;
      logic [6:0] led2_torch;
      logic short_det_en;
      logic pass_mode;
      logic freq_4mhz;
      logic ilim_high;
      logic [2:0] ramp_code;
      logic [3:0] timeout_code;
      logic pin_active_low;
      logic pin_pulldown_en;
      logic therm_open_en;
      logic therm_short_en;
      logic [2:0] therm_thr_code;
      logic pin_is_thermistor;
      logic [6:0] indicator;
   } fdc_cfg_t;

endpackage : fdc_pkg

// ### rtl/fdc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_params.svh"

// What this block does
// - LED2 flash code in bits 6:0, default 0111111, bit 7 reads zero.
// - LED1 torch bit 7 set makes LED2 torch follow LED1 torch code.
// - LED1 torch code in bits 6:0 with default giving 186 mA.
// - LED2 torch own code in bits 6:0, same default, bit 7 reserved.
// - Boost bits: short detect, pass mode, frequency, current limit, soft reset.
// - Timing bits 6:4 pick torch ramp time, default 1 ms.
// - Timing bits 3:0 pick one of sixteen flash timeouts, default code 1010.
// - Thermistor bit 6 sets pin polarity and pull-down.
// - Bit 0 picks pin function; bits 5 and 4 enable open and short checks.
// - First flag register reports eight events, bit 7 down to bit 0.
// - Second flag register reports five events in bits 4:0.
// - Indicator register holds a 7-bit scaling code.
// - LED1 flash override makes led2_flash_eff follow LED1 flash code; cfg.led2_flash keeps the LED2 flash code.
module fdc_regs
(
   // Core domain
   input wire logic core_clk,
   input wire logic sys_rst,
   // Link domain, serial engine side
   input wire logic lnk_clk,
   input wire logic lnk_req_valid,
   output logic lnk_req_ready,
   input wire fdc_pkg::fdc_req_t lnk_req,
   output logic lnk_rsp_valid,
   output logic [7:0] lnk_rsp_rdata,
   // Settings from the preceding registers
   input wire logic led2_flash_follow,
   input wire logic [6:0] led1_flash_code,
   // Status from the analog section
   input wire logic [7:0] fault_primary,
   input wire logic [4:0] fault_secondary,
   input wire logic [6:0] input_voltage_monitor_code,
   // Outputs to the analog section
   output fdc_pkg::fdc_cfg_t cfg,
   output logic [6:0] led2_flash_eff,
   output logic soft_reset
);

   // ------------------------------------------------------------
   // Link side request hold and toggles
   // ------------------------------------------------------------
   fdc_pkg::fdc_req_t hold_ff;
   logic req_tgl_ff;
   logic busy_ff;
   logic ack_s1_ff;
   logic ack_s2_ff;
   logic ack_s3_ff;
   logic rsp_valid_ff;
   logic [7:0] rsp_rdata_ff;
   logic ack_seen;

   // Core side
   logic req_s1_ff;
   logic req_s2_ff;
   logic req_s3_ff;
   logic ack_tgl_ff;
   logic [7:0] core_rdata_ff;
   logic acc_go;

   logic [6:0] led2_flash_ff;
   logic [7:0] led1_torch_ff;
   logic [6:0] led2_torch_ff;
   logic [3:0] boost_ff;
   logic [6:0] timing_ff;
   logic [6:0] therm_ff;
   logic [6:0] indicator_ff;
   logic [7:0] unlock_ff;
   logic swrst_ff;

   logic [7:0] fp_s1_ff;
   logic [7:0] fp_s2_ff;
   logic [4:0] fs_s1_ff;
   logic [4:0] fs_s2_ff;
   logic [7:0] flags1_ff;
   logic [4:0] flags2_ff;

   fdc_pkg::fdc_cfg_t cfg_ff;
   logic [6:0] led2_flash_eff_ff;
   logic [7:0] nxt_rdata;
   logic wr_go;
   logic rd_go;

   assign ack_seen = ack_s2_ff ^ ack_s3_ff;
   assign lnk_req_ready = ~busy_ff;

   always_ff @(posedge lnk_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hold_ff <= '0;
         req_tgl_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else if (lnk_req_valid && !busy_ff)
      begin
         hold_ff <= lnk_req;
         req_tgl_ff <= ~req_tgl_ff;
         busy_ff <= 1'b1;
      end
      else if (ack_seen)
      begin
         busy_ff <= 1'b0;
      end
   end

   always_ff @(posedge lnk_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         ack_s3_ff <= 1'b0;
      end
      else
      begin
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_s3_ff <= ack_s2_ff;
      end
   end

   // Read data is stable in the core register once the ack is seen
   always_ff @(posedge lnk_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= `FDC_ZERO8;
      end
      else
      begin
         rsp_valid_ff <= ack_seen;
         if (ack_seen)
         begin
            rsp_rdata_ff <= core_rdata_ff;
         end
      end
   end

   assign lnk_rsp_valid = rsp_valid_ff;
   assign lnk_rsp_rdata = rsp_rdata_ff;

   // ------------------------------------------------------------
   // Core side crossing
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_s3_ff <= 1'b0;
      end
      else
      begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
      end
   end

   assign acc_go = req_s2_ff ^ req_s3_ff;
   assign wr_go = acc_go & hold_ff.wr;
   assign rd_go = acc_go & ~hold_ff.wr;

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         led2_flash_ff <= `FDC_RST_LED2_FLASH;
         led1_torch_ff <= `FDC_RST_LED1_TORCH;
         led2_torch_ff <= `FDC_RST_LED2_TORCH;
         boost_ff <= `FDC_RST_BOOST;
         timing_ff <= `FDC_RST_TIMING;
         therm_ff <= `FDC_RST_THERM;
         indicator_ff <= `FDC_RST_INDICATOR;
         unlock_ff <= `FDC_RST_UNLOCK;
      end
      else if (swrst_ff)
      begin
         led2_flash_ff <= `FDC_RST_LED2_FLASH;
         led1_torch_ff <= `FDC_RST_LED1_TORCH;
         led2_torch_ff <= `FDC_RST_LED2_TORCH;
         boost_ff <= `FDC_RST_BOOST;
         timing_ff <= `FDC_RST_TIMING;
         therm_ff <= `FDC_RST_THERM;
         indicator_ff <= `FDC_RST_INDICATOR;
         unlock_ff <= `FDC_RST_UNLOCK;
      end
      else if (wr_go)
      begin
         unique case (hold_ff.addr)
            `FDC_OFS_LED2_FLASH: led2_flash_ff <= hold_ff.wdata[6:0];
            `FDC_OFS_LED1_TORCH: led1_torch_ff <= hold_ff.wdata;
            `FDC_OFS_LED2_TORCH: led2_torch_ff <= hold_ff.wdata[6:0];
            `FDC_OFS_BOOST: boost_ff <= hold_ff.wdata[3:0];
            `FDC_OFS_TIMING: timing_ff <= hold_ff.wdata[6:0];
            `FDC_OFS_THERM: therm_ff <= hold_ff.wdata[6:0];
            `FDC_OFS_UNLOCK: unlock_ff <= hold_ff.wdata;
            `FDC_OFS_INDICATOR:
            begin
               if (unlock_ff == `FDC_UNLOCK_KEY)
               begin
                  indicator_ff <= hold_ff.wdata[6:0];
               end
            end
            default:
            begin
               // Read-only and unmapped writes are dropped
               unlock_ff <= unlock_ff;
            end
         endcase
      end
   end

   // Soft reset bit self-clears, reads back zero
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         swrst_ff <= 1'b0;
      end
      else
      begin
         swrst_ff <= wr_go && (hold_ff.addr == `FDC_OFS_BOOST)
                     && hold_ff.wdata[`FDC_SWRST_BIT];
      end
   end

   assign soft_reset = swrst_ff;

   // ------------------------------------------------------------
   // Fault flags: synchronised, sticky, cleared by read
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         fp_s1_ff <= '0;
         fp_s2_ff <= '0;
         fs_s1_ff <= '0;
         fs_s2_ff <= '0;
      end
      else
      begin
         fp_s1_ff <= fault_primary;
         fp_s2_ff <= fp_s1_ff;
         fs_s1_ff <= fault_secondary;
         fs_s2_ff <= fs_s1_ff;
      end
   end

   // Set wins over the read clear
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flags1_ff <= '0;
         flags2_ff <= '0;
      end
      else
      begin
         flags1_ff <= (flags1_ff
                      & ~{8{rd_go && (hold_ff.addr == `FDC_OFS_FLAGS1)}})
                      | fp_s2_ff;
         flags2_ff <= (flags2_ff
                      & ~{`FDC_FLAGS2_W{rd_go
                        && (hold_ff.addr == `FDC_OFS_FLAGS2)}})
                      | fs_s2_ff;
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_rdata = `FDC_ZERO8;
      unique case (hold_ff.addr)
         `FDC_OFS_LED2_FLASH: nxt_rdata = {1'b0, led2_flash_ff};
         `FDC_OFS_LED1_TORCH: nxt_rdata = led1_torch_ff;
         `FDC_OFS_LED2_TORCH: nxt_rdata = {1'b0, led2_torch_ff};
         `FDC_OFS_BOOST: nxt_rdata = {4'h0, boost_ff};
         `FDC_OFS_TIMING: nxt_rdata = {1'b0, timing_ff};
         `FDC_OFS_THERM: nxt_rdata = {1'b0, therm_ff};
         `FDC_OFS_FLAGS1: nxt_rdata = flags1_ff;
         `FDC_OFS_FLAGS2: nxt_rdata = {3'h0, flags2_ff};
         `FDC_OFS_IDENT: nxt_rdata = {2'h0, `FDC_DEV_CODE,
                                      `FDC_REV_CODE};
         `FDC_OFS_LAST_FLASH:
            nxt_rdata = {1'b0, input_voltage_monitor_code};
         `FDC_OFS_INDICATOR: nxt_rdata = {1'b0, indicator_ff};
         `FDC_OFS_UNLOCK: nxt_rdata = unlock_ff;
         default: nxt_rdata = `FDC_ZERO8;
      endcase
   end

   // Read data captured on the same edge that toggles the ack
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         core_rdata_ff <= `FDC_ZERO8;
         ack_tgl_ff <= 1'b0;
      end
      else if (acc_go)
      begin
         core_rdata_ff <= hold_ff.wr ? `FDC_ZERO8 : nxt_rdata;
         ack_tgl_ff <= ~ack_tgl_ff;
      end
   end

   // ------------------------------------------------------------
   // Settings to the analog section
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg_ff <= '0;
         led2_flash_eff_ff <= '0;
      end
      else
      begin
         cfg_ff.led2_flash <= led2_flash_ff;
         cfg_ff.led1_torch <= led1_torch_ff[6:0];
         cfg_ff.led2_torch <= led1_torch_ff[`FDC_FOLLOW_BIT] ?
                              led1_torch_ff[6:0] : led2_torch_ff;
         cfg_ff.short_det_en <= boost_ff[`FDC_SHORT_DET_BIT];
         cfg_ff.pass_mode <= boost_ff[`FDC_PASS_BIT];
         cfg_ff.freq_4mhz <= boost_ff[`FDC_FREQ_BIT];
         cfg_ff.ilim_high <= boost_ff[`FDC_ILIM_BIT];
         cfg_ff.ramp_code <= timing_ff[`FDC_RAMP_MSB:`FDC_RAMP_LSB];
         cfg_ff.timeout_code <= timing_ff[`FDC_TMO_MSB:`FDC_TMO_LSB];
         cfg_ff.pin_active_low <= therm_ff[`FDC_POL_BIT];
         cfg_ff.pin_pulldown_en <= ~therm_ff[`FDC_POL_BIT];
         cfg_ff.therm_open_en <= therm_ff[`FDC_OPEN_EN_BIT];
         cfg_ff.therm_short_en <= therm_ff[`FDC_SHORT_EN_BIT];
         cfg_ff.therm_thr_code <= therm_ff[`FDC_THR_MSB:`FDC_THR_LSB];
         cfg_ff.pin_is_thermistor <= therm_ff[`FDC_FUNC_BIT];
         cfg_ff.indicator <= indicator_ff;
         led2_flash_eff_ff <= led2_flash_follow ?
                              led1_flash_code : led2_flash_ff;
      end
   end

   assign cfg = cfg_ff;
   assign led2_flash_eff = led2_flash_eff_ff;

endmodule : fdc_regs

`default_nettype wire

// ### testbench/fdc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_regs_asserts
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic lnk_clk,
   input wire logic lnk_req_valid,
   input wire logic lnk_req_ready,
   input wire logic lnk_rsp_valid,
   input wire logic [7:0] lnk_rsp_rdata,
   input wire logic led2_flash_follow,
   input wire logic [6:0] led1_flash_code,
   input wire fdc_pkg::fdc_cfg_t cfg,
   input wire logic [6:0] led2_flash_eff,
   input wire logic soft_reset
);
   // ------
   // Link
   // ------
   a_rsp_one_pulse:
   assert property (@(posedge lnk_clk) disable iff (sys_rst)
      lnk_rsp_valid |=> !lnk_rsp_valid) else $error("rsp too long");
   a_accept_busy:
   assert property (@(posedge lnk_clk) disable iff (sys_rst)
      lnk_req_valid && lnk_req_ready |=> !lnk_req_ready) else $error("no busy");
   a_rsp_in_time:
   assert property (@(posedge lnk_clk) disable iff (sys_rst)
      lnk_req_valid && lnk_req_ready |-> ##[4:8] lnk_rsp_valid)
      else $error("no rsp");
   a_ready_at_rsp:
   assert property (@(posedge lnk_clk) disable iff (sys_rst)
      lnk_rsp_valid |-> lnk_req_ready) else $error("not ready at rsp");
   a_rdata_hold:
   assert property (@(posedge lnk_clk) disable iff (sys_rst)
      !lnk_rsp_valid |-> $stable(lnk_rsp_rdata)) else $error("rdata moved");
   // ------
   // Core
   // ------
   a_soft_pulse:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      soft_reset |=> !soft_reset) else $error("soft reset too long");
   a_soft_defaults:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      soft_reset |-> ##[1:3] (cfg.timeout_code == 4'hA
      && cfg.ramp_code == 3'h1 && cfg.indicator == 7'h7F))
      else $error("defaults not restored");
   a_flash_follow:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(sys_rst) && $past(led2_flash_follow) |->
      led2_flash_eff == $past(led1_flash_code)) else $error("follow wrong");
   a_pin_polarity:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cfg.pin_pulldown_en != cfg.pin_active_low)
      else $error("pulldown wrong");
   c_accept: cover property (@(posedge lnk_clk) disable iff (sys_rst)
      lnk_req_valid && lnk_req_ready);
   c_soft: cover property (@(posedge core_clk) disable iff (sys_rst)
      soft_reset);
   c_follow: cover property (@(posedge core_clk) disable iff (sys_rst)
      led2_flash_follow ##1 !led2_flash_follow);
endmodule : fdc_regs_asserts
`default_nettype wire

// ### testbench/fdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_host_model
(
   input wire logic lnk_clk,
   output logic lnk_req_valid,
   input wire logic lnk_req_ready,
   output fdc_pkg::fdc_req_t lnk_req,
   input wire logic lnk_rsp_valid,
   input wire logic [7:0] lnk_rsp_rdata
);
   initial
   begin
      lnk_req_valid = 1'b0;
      lnk_req = '0;
   end
   // One access held until taken; slow adds idle edges first
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, input int slow);
      int n;
      q = 'x;
      repeat (slow) @(posedge lnk_clk);
      @(posedge lnk_clk);
      #1;
      lnk_req = {wr, a, d};
      lnk_req_valid = 1'b1;
      @(posedge lnk_clk);
      while (!lnk_req_ready)
         @(posedge lnk_clk);
      #1;
      lnk_req_valid = 1'b0;
      lnk_req = ~lnk_req;
      n = 0;
      while (n < 20)
      begin
         @(posedge lnk_clk);
         #1;
         if (lnk_rsp_valid)
         begin
            q = lnk_rsp_rdata;
            n = 20;
         end
         n++;
      end
   endtask : xfer
endmodule : fdc_host_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk, lnk_clk, sys_rst, req_valid, req_ready, rsp_valid;
   logic follow, soft_reset;
   logic [7:0] rdata, f1, q;
   logic [4:0] f2;
   logic [6:0] fl_code, ivm, eff;
   logic [7:0] mdl [0:127];
   fdc_pkg::fdc_req_t req;
   fdc_pkg::fdc_cfg_t cfg;
   int err_count, tests_run, seed, i, j;

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial
   begin
      lnk_clk = 1'b0;
      #7;
      forever #15 lnk_clk = ~lnk_clk;
   end

   fdc_regs i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .lnk_clk(lnk_clk),
      .lnk_req_valid(req_valid), .lnk_req_ready(req_ready), .lnk_req(req),
      .lnk_rsp_valid(rsp_valid), .lnk_rsp_rdata(rdata),
      .led2_flash_follow(follow), .led1_flash_code(fl_code),
      .fault_primary(f1), .fault_secondary(f2),
      .input_voltage_monitor_code(ivm), .cfg(cfg), .led2_flash_eff(eff),
      .soft_reset(soft_reset));
   fdc_host_model i_host (.lnk_clk(lnk_clk), .lnk_req_valid(req_valid),
      .lnk_req_ready(req_ready), .lnk_req(req), .lnk_rsp_valid(rsp_valid),
      .lnk_rsp_rdata(rdata));

   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] s);
      tests_run++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask : chk

   task automatic set_def;
      mdl = '{default: 8'h00};
      mdl[8'h04] = 8'h3F;
      mdl[8'h05] = 8'hBF;
      mdl[8'h06] = 8'h3F;
      mdl[8'h07] = 8'h09;
      mdl[8'h08] = 8'h1A;
      mdl[8'h09] = 8'h08;
      mdl[8'h0C] = 8'h29;
      mdl[8'h39] = 8'h7F;
   endtask : set_def

   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h05, 8'h69: return 8'hFF;
         8'h04, 8'h06, 8'h08, 8'h09: return 8'h7F;
         8'h07: return 8'h0F;
         8'h39: return (mdl[8'h69] === 8'h02) ? 8'h7F : 8'h00;
         default: return 8'h00;
      endcase
   endfunction : wmask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = wmask(a);
      i_host.xfer(1'b1, a, d, q, int'(seed[1:0]));
      chk("write rdata", 8'h00, q);
      mdl[a] = (mdl[a] & ~m) | (d & m);
      if (a == 8'h07 && d[7])
         set_def();
      repeat (4) @(posedge core_clk);
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      if (a == 8'h0D)
         mdl[a] = {1'b0, ivm};
      e = mdl[a];
      i_host.xfer(1'b0, a, 8'($random(seed)), q, int'(seed[2:1]));
      chk($sformatf("reg %h", a), e, q);
      if (a == 8'h0A || a == 8'h0B)
         mdl[a] = 8'h00;
   endtask : rd

   task automatic chk_cfg;
      logic [7:0] t;
      logic [7:0] b;
      logic [7:0] r;
      logic [7:0] m;
      t = mdl[8'h05][7] ? mdl[8'h05] : mdl[8'h06];
      b = {4'h0, cfg.short_det_en, cfg.pass_mode, cfg.freq_4mhz,
         cfg.ilim_high};
      r = {1'b0, cfg.ramp_code, cfg.timeout_code};
      m = {1'b0, cfg.pin_active_low, cfg.therm_open_en, cfg.therm_short_en,
         cfg.therm_thr_code, cfg.pin_is_thermistor};
      chk("led1_torch", mdl[8'h05] & 8'h7F, 8'(cfg.led1_torch));
      chk("led2_torch", t & 8'h7F, 8'(cfg.led2_torch));
      chk("led2_flash", mdl[8'h04], 8'(cfg.led2_flash));
      chk("flash_eff", follow ? 8'(fl_code) : mdl[8'h04], 8'(eff));
      chk("boost", mdl[8'h07], b);
      chk("timing", mdl[8'h08], r);
      chk("therm", mdl[8'h09], m);
      chk("pulldown", {7'h00, ~mdl[8'h09][6]}, 8'(cfg.pin_pulldown_en));
      chk("indicator", mdl[8'h39], 8'(cfg.indicator));
   endtask : chk_cfg

   task automatic end_sim;
      if (err_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   initial
   begin
      #400000;
      err_count++;
      end_sim();
   end

   initial
   begin
      err_count = 0;
      tests_run = 0;
      seed = 32'h214EDE4E;
      sys_rst = 1'b1;
      follow = 1'b1;
      fl_code = 7'h00;
      f1 = 8'h00;
      f2 = 5'h00;
      ivm = 7'h11;
      set_def();
      repeat (20) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      chk_cfg();
      for (i = 0; i < 128; i++)
         rd(8'(i));
      for (j = 0; j < 6; j++)
      begin
         follow = seed[3];
         fl_code = 7'($random(seed));
         for (i = 4; i < 10; i++)
            wr(8'(i), 8'($random(seed)) & ((i == 7) ? 8'h7F : 8'hFF));
         chk_cfg();
         for (i = 4; i < 10; i++)
            rd(8'(i));
      end
      wr(8'h04, 8'hFF);
      rd(8'h04);
      // ------
      // Indicator lock
      // ------
      wr(8'h39, 8'h15);
      rd(8'h39);
      wr(8'h69, 8'h02);
      wr(8'h39, 8'h15);
      chk_cfg();
      wr(8'h69, 8'h00);
      wr(8'h39, 8'h55);
      rd(8'h39);
      wr(8'h69, 8'h02);
      wr(8'h39, 8'h7F);
      wr(8'h69, 8'h00);
      // ------
      // Flags and read-only
      // ------
      for (i = 10; i < 14; i++)
         wr(8'(i), 8'hFF);
      f1 = 8'($random(seed));
      f2 = 5'($random(seed));
      ivm = 7'($random(seed));
      mdl[8'h0A] = f1;
      mdl[8'h0B] = {3'h0, f2};
      repeat (6) @(posedge core_clk);
      #1;
      f1 = 8'h00;
      f2 = 5'h00;
      for (i = 10; i < 14; i++)
         rd(8'(i));
      rd(8'h0A);
      rd(8'h0B);
      // ------
      // Soft reset
      // ------
      wr(8'h69, 8'h02);
      wr(8'h07, 8'h86);
      chk_cfg();
      for (i = 4; i < 10; i++)
         rd(8'(i));
      rd(8'h69);
      end_sim();
   end
endmodule : tb_top

bind fdc_regs fdc_regs_asserts i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .lnk_clk(lnk_clk), .lnk_req_valid(lnk_req_valid),
   .lnk_req_ready(lnk_req_ready), .lnk_rsp_valid(lnk_rsp_valid),
   .lnk_rsp_rdata(lnk_rsp_rdata), .led2_flash_follow(led2_flash_follow),
   .led1_flash_code(led1_flash_code), .cfg(cfg),
   .led2_flash_eff(led2_flash_eff), .soft_reset(soft_reset));
`default_nettype wire
